// ---- verilog/vrc_map.svh ----
/*
 * Register map and field constants for the voltage reference control block.
 * Assumes an 8-bit register file reached over classic Wishbone with 32-bit data.
 */
`ifndef VRC_MAP_SVH
`define VRC_MAP_SVH

// ****************************************************************
// Register indices and address width
// ****************************************************************
`define VRC_IDX_COMPARATOR_CONTROL 8'h1F
`define VRC_IDX_PORT_A_DIRECTION 8'h85
`define VRC_IDX_REF_CONTROL 8'h9F
`define VRC_IDX_STATUS 8'hA0
`define VRC_ADDR_W 10

// ****************************************************************
// Reset values
// ****************************************************************
`define VRC_RST_COMPARATOR_CONTROL 8'h00
`define VRC_RST_PORT_A_DIRECTION 8'hFF
`define VRC_RST_REF_CONTROL 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define VRC_BIT_REF_ENABLE 7
`define VRC_BIT_PIN_DRIVE 6
`define VRC_BIT_RANGE 5
`define VRC_BIT_UNUSED 4
`define VRC_TAP_HI 3
`define VRC_TAP_LO 0
`define VRC_MODE_HI 2
`define VRC_MODE_LO 0
`define VRC_OUT_PIN_BIT 2
`define VRC_CTRL_WMASK 8'hEF

// ****************************************************************
// Comparator mode that routes the internal reference
// ****************************************************************
`define VRC_MODE_INT_REF 3'h2

`endif

// ---- verilog/vrc_pkg.sv ----
/*
 * Types shared by the voltage reference control block.
 * Assumes the constants of vrc_map.svh.
 */
package vrc_pkg;
    typedef logic [7:0] vrc_byte_t;
    typedef enum logic {
        VRC_RANGE_HIGH,
        VRC_RANGE_LOW
    } vrc_range_e;
endpackage : vrc_pkg

// ---- verilog/vrc_tap_decode.sv ----
/*
 * Ladder tap decoder: one-hot tap select and range segment controls.
 * Assumes registered control inputs on the same clock as the caller.
 */
`timescale 1ns/1ps
`include "vrc_map.svh"
module vrc_tap_decode
    import vrc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Settings
    input wire logic enable_i,
    input wire logic range_low_i,
    input wire logic [3:0] tap_i,
    // Ladder controls
    output logic [15:0] tap_onehot_o,
    output logic powered_o,
    output logic bottom_short_o,
    output logic quarter_seg_o
);
    // ****************************************************************
    // One flip-flop per tap
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_tap
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    tap_onehot_o[g] <= 1'b0;
                end else begin
                    tap_onehot_o[g] <= enable_i && (tap_i == 4'(g));
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Range segments: low range is tap/24, high range is 1/4 plus tap/32
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            powered_o <= 1'b0;
            bottom_short_o <= 1'b0;
            quarter_seg_o <= 1'b0;
        end else begin
            powered_o <= enable_i;
            bottom_short_o <= enable_i && range_low_i;
            quarter_seg_o <= enable_i && !range_low_i;
        end
    end
endmodule : vrc_tap_decode

// ---- verilog/vrc_ctrl.sv ----
/*
 * Voltage reference control: ref_control, comparator_control and
 * port_a_direction registers behind a classic Wishbone slave, ladder
 * controls, pin routing and comparator reference routing.
 * Assumes a single 50 MHz clock, synchronous active-high reset, and that
 * sleep only gates the analog side and never touches this register file.
 */
// Behaviour
// - Four-bit tap select picks one of sixteen levels within the range.
// - Range 1 gives tap/24 of supply; range 0 gives quarter plus tap/32.
// - Ladder powered only while the reference enable bit is set.
// - Reset clears the reference enable bit, bit 7.
// - Reset clears pin drive enable and range select bits.
// - Reset clears all four tap select bits.
// - Sleep wake-up leaves every control bit unchanged.
// - Pin driven only when its direction bit and drive enable are set.
// - Reference control is independent of comparator settings.
// - Control register resets to zero; bit 4 always reads zero.
// - Comparator mode 010 routes the reference to both comparator inputs.
`timescale 1ns/1ps
`include "vrc_map.svh"
module vrc_ctrl
    import vrc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [`VRC_ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Power state
    input wire logic sleep_i,
    // Comparator outputs into comparator_control bits 7:6
    input wire logic [1:0] cmp_out_i,
    // Ladder controls
    output logic [15:0] tap_onehot_o,
    output logic ladder_power_o,
    output logic ladder_bottom_short_o,
    output logic ladder_quarter_seg_o,
    // Routing
    output logic ref_pin_connect_o,
    output logic cmp_ref_select_o,
    output logic [2:0] comparator_mode_o
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    vrc_byte_t ref_control_reg;
    vrc_byte_t comparator_control_reg;
    vrc_byte_t port_a_direction_reg;
    logic [7:0] idx;
    logic req;
    logic wr_lane0;
    vrc_range_e range_sel;

    assign idx = adr_i[9:2];
    assign req = cyc_i && stb_i && !ack_o;
    assign wr_lane0 = req && we_i && sel_i[0];

    // ****************************************************************
    // Wishbone answer: one wait state, ack for one cycle
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            case (idx)
                `VRC_IDX_REF_CONTROL: dat_o <= {24'h00_0000, ref_control_reg};
                `VRC_IDX_COMPARATOR_CONTROL: dat_o <= {24'h00_0000, comparator_control_reg};
                `VRC_IDX_PORT_A_DIRECTION: dat_o <= {24'h00_0000, port_a_direction_reg};
                `VRC_IDX_STATUS: dat_o <= {29'h0, ladder_power_o,
                    ref_pin_connect_o, cmp_ref_select_o};
                default: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // ref_control: no sleep term, so wake-up preserves it
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_control_reg <= `VRC_RST_REF_CONTROL;
        end else if (wr_lane0 && idx == `VRC_IDX_REF_CONTROL) begin
            ref_control_reg <= dat_i[7:0] & `VRC_CTRL_WMASK;
        end
    end

    // ****************************************************************
    // comparator_control: outputs read-only, low six bits writable
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comparator_control_reg <= `VRC_RST_COMPARATOR_CONTROL;
        end else begin
            comparator_control_reg[7:6] <= cmp_out_i;
            if (wr_lane0 && idx == `VRC_IDX_COMPARATOR_CONTROL) begin
                comparator_control_reg[5:0] <= dat_i[5:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_a_direction_reg <= `VRC_RST_PORT_A_DIRECTION;
        end else if (wr_lane0 && idx == `VRC_IDX_PORT_A_DIRECTION) begin
            port_a_direction_reg <= dat_i[7:0];
        end
    end

    // ****************************************************************
    // Routing outputs
    // ****************************************************************
    assign range_sel = ref_control_reg[`VRC_BIT_RANGE] ? VRC_RANGE_LOW : VRC_RANGE_HIGH;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_pin_connect_o <= 1'b0;
            cmp_ref_select_o <= 1'b0;
            comparator_mode_o <= 3'h0;
        end else begin
            ref_pin_connect_o <= port_a_direction_reg[`VRC_OUT_PIN_BIT]
                && ref_control_reg[`VRC_BIT_PIN_DRIVE];
            cmp_ref_select_o <= comparator_control_reg[`VRC_MODE_HI:`VRC_MODE_LO]
                == `VRC_MODE_INT_REF;
            comparator_mode_o <= comparator_control_reg[`VRC_MODE_HI:`VRC_MODE_LO];
        end
    end

    // ****************************************************************
    // Ladder decoder
    // ****************************************************************
    vrc_tap_decode u_tap (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(ref_control_reg[`VRC_BIT_REF_ENABLE]),
        .range_low_i(range_sel == VRC_RANGE_LOW),
        .tap_i(ref_control_reg[`VRC_TAP_HI:`VRC_TAP_LO]),
        .tap_onehot_o(tap_onehot_o),
        .powered_o(ladder_power_o),
        .bottom_short_o(ladder_bottom_short_o),
        .quarter_seg_o(ladder_quarter_seg_o)
    );

    logic unused_sleep;
    assign unused_sleep = sleep_i;
endmodule : vrc_ctrl

// ---- tb/vrc_ctrl_sva.sv ----
/* Checker for vrc_ctrl port behaviour.
   Assumes Wishbone requests are held until ack, as the bench drives them. */
`timescale 1ns/1ps
`include "vrc_map.svh"
module vrc_ctrl_sva
    import vrc_pkg::*;
(
    // Clock, reset, bus and power state
    input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sleep_i,
    input wire logic [`VRC_ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i, dat_o,
    // Ladder and routing
    input wire logic [15:0] tap_onehot_o,
    input wire logic ladder_power_o, ladder_bottom_short_o, ladder_quarter_seg_o,
    input wire logic ref_pin_connect_o, cmp_ref_select_o,
    input wire logic [2:0] comparator_mode_o
);
// ****************************************
// Write tracking and properties
// ****************************************
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
wire hit = cyc_i && stb_i && we_i && ack_o && sel_i[0];
wire [7:0] idx = adr_i[9:2];
vrc_byte_t ref_reg;
vrc_byte_t dir_reg;
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        ref_reg <= 8'h00;
        dir_reg <= 8'hFF;
    end else begin
        if (hit && idx == `VRC_IDX_REF_CONTROL) ref_reg <= dat_i[7:0];
        if (hit && idx == `VRC_IDX_PORT_A_DIRECTION) dir_reg <= dat_i[7:0];
    end
end
property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
a_ack: assert property (p_ack) else $error("ack not a single pulse");
property p_pow; hit && idx == `VRC_IDX_REF_CONTROL |-> ##2 ladder_power_o == ref_reg[7]
    && tap_onehot_o == (ref_reg[7] ? 16'h0001 << ref_reg[3:0] : 16'h0000); endproperty
a_pow: assert property (p_pow) else $error("power or tap wrong");
property p_rng; hit && idx == `VRC_IDX_REF_CONTROL |-> ##2 ladder_bottom_short_o ==
    (ref_reg[7] & ref_reg[5]) && ladder_quarter_seg_o == (ref_reg[7] & !ref_reg[5]); endproperty
a_rng: assert property (p_rng) else $error("range segment wrong");
property p_pin; hit && (idx == `VRC_IDX_REF_CONTROL || idx == `VRC_IDX_PORT_A_DIRECTION)
    |-> ##2 ref_pin_connect_o == (dir_reg[2] & ref_reg[6]); endproperty
a_pin: assert property (p_pin) else $error("pin routing wrong");
property p_mode; hit && idx == `VRC_IDX_COMPARATOR_CONTROL |-> ##2 comparator_mode_o ==
    $past(dat_i[2:0], 2) && cmp_ref_select_o == ($past(dat_i[2:0], 2) == 3'h2); endproperty
a_mode: assert property (p_mode) else $error("comparator routing wrong");
property p_rst; $fell(rst_i) |-> !ladder_power_o && tap_onehot_o == 16'h0000
    && !ref_pin_connect_o && !ladder_bottom_short_o; endproperty
a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
property p_rd; cyc_i && ack_o && !we_i && idx == `VRC_IDX_REF_CONTROL |->
    dat_o == {24'h000000, ref_reg & `VRC_CTRL_WMASK}; endproperty
a_rd: assert property (p_rd) else $error("control read value wrong");
property p_slp; sleep_i && !cyc_i && !$past(cyc_i) |=> $stable(tap_onehot_o)
    && $stable(ladder_power_o) && $stable(ref_pin_connect_o); endproperty
a_slp: assert property (p_slp) else $error("settings moved in sleep");
endmodule : vrc_ctrl_sva
bind vrc_ctrl vrc_ctrl_sva u_sva (.*);

// ---- tb/test_voltage_reference_control.sv ----
/* Self-checking bench for vrc_ctrl over classic Wishbone.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`include "vrc_map.svh"
module test_voltage_reference_control
    import vrc_pkg::*;
;
// ****************************************
// Stimulus and checks
// ****************************************
logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, sleep_i = 1'h0;
logic [9:0] adr_i = 10'h000;
logic [3:0] sel_i = 4'h0;
logic [31:0] dat_i = 32'h0, dat_o, q;
logic [1:0] cmp_out_i = 2'h0;
logic [15:0] tap_onehot_o;
logic [2:0] comparator_mode_o;
logic ack_o, ladder_power_o, ladder_bottom_short_o, ladder_quarter_seg_o;
logic ref_pin_connect_o, cmp_ref_select_o;
int n_fail = 0, check_count = 0;
vrc_byte_t ref_v, dir_v, cmp_v;
wire [31:0] outs = {8'h00, tap_onehot_o, ladder_power_o, ladder_bottom_short_o,
    ladder_quarter_seg_o, ref_pin_connect_o, cmp_ref_select_o, comparator_mode_o};
always #10 clk_i = ~clk_i;
vrc_ctrl u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .sleep_i(sleep_i),
    .cmp_out_i(cmp_out_i),
    .tap_onehot_o(tap_onehot_o),
    .ladder_power_o(ladder_power_o),
    .ladder_bottom_short_o(ladder_bottom_short_o),
    .ladder_quarter_seg_o(ladder_quarter_seg_o),
    .ref_pin_connect_o(ref_pin_connect_o),
    .cmp_ref_select_o(cmp_ref_select_o),
    .comparator_mode_o(comparator_mode_o)
);
function automatic logic [31:0] exp_out(vrc_byte_t r, vrc_byte_t d, vrc_byte_t c);
    return {8'h00, r[7] ? 16'h0001 << r[3:0] : 16'h0000, r[7], r[7] & r[5], r[7] & ~r[5],
        d[2] & r[6], c[2:0] == 3'h2, c[2:0]};
endfunction : exp_out
task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
        $display("RESULT: PASS");
    end else begin
        $display("RESULT: FAIL");
    end
    $finish;
endtask : give_verdict
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
        n_fail++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask : chk
task automatic wb(input logic w, input logic [9:0] a, input vrc_byte_t d, input logic s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    sel_i <= {3'h0, s};
    dat_i <= {24'h000000, d};
    do begin
        @(posedge clk_i);
        n++;
    end while (ack_o !== 1'h1 && n < 20);
    if (ack_o !== 1'h1) begin
        n_fail++;
        give_verdict();
    end
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
endtask : wb
initial begin
    void'($urandom(36));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 10'h27C, 8'h00, 1'h1);
    chk(q, 32'h00);
    wb(1'h0, 10'h214, 8'h00, 1'h1);
    chk(q, 32'hFF);
    for (int i = 0; i < 24; i++) begin
        ref_v = (i == 0) ? 8'hFF : 8'($urandom);
        dir_v = (i == 1) ? 8'h00 : 8'($urandom);
        cmp_v = {2'($urandom), 3'($urandom), i[2:0]};
        @(posedge clk_i);
        cmp_out_i <= 2'($urandom);
        wb(1'h1, 10'h27C, ref_v, 1'h1);
        wb(1'h1, 10'h214, dir_v, 1'h1);
        wb(1'h1, 10'h07C, cmp_v, 1'h1);
        wb(1'h0, 10'h27C, 8'h00, 1'h1);
        chk(q, {24'h000000, ref_v & 8'hEF});
        wb(1'h0, 10'h07C, 8'h00, 1'h1);
        chk(q, {24'h000000, cmp_out_i, cmp_v[5:0]});
        wb(1'h0, 10'h280, 8'h00, 1'h1);
        chk(q, {29'h0, ref_v[7], dir_v[2] & ref_v[6], cmp_v[2:0] == 3'h2});
        repeat (2) @(negedge clk_i);
        chk(outs, exp_out(ref_v & 8'hEF, dir_v, cmp_v));
    end
    ref_v = ref_v & 8'h6F;
    wb(1'h1, 10'h27C, ref_v, 1'h1);
    sleep_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    sleep_i <= 1'h0;
    wb(1'h1, 10'h27C, 8'h00, 1'h0);
    wb(1'h1, 10'h3F0, 8'h5A, 1'h1);
    wb(1'h0, 10'h3F0, 8'h00, 1'h1);
    chk(q, 32'h00);
    wb(1'h0, 10'h27C, 8'h00, 1'h1);
    chk(q, {24'h000000, ref_v & 8'hEF});
    wb(1'h1, 10'h27C, 8'hFF, 1'h1);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 10'h27C, 8'h00, 1'h1);
    chk(q, 32'h00);
    @(negedge clk_i);
    chk(outs, exp_out(8'h00, 8'hFF, 8'h00));
    give_verdict();
end
endmodule : test_voltage_reference_control
